/* redriver_pkg.sv */
package redriver_pkg;

  // Configuration source chosen when the chip enable rises.
  typedef enum logic {
    mode_strap,
    mode_serial
  } cfg_mode_e;

  // Receiver sensitivity levels.
  typedef enum logic [1:0] {
    sens_low,
    sens_medium,
    sens_high
  } sens_level_e;

  // Width of the boost selection.
  localparam int unsigned boost_w = 2;

  // Reset value of the latched boost configuration.
  localparam logic [1:0] boost_reset = 2'h0;

  // Width and bit positions of the synchronised strap and pin word.
  localparam int unsigned pin_w = 7;
  localparam int unsigned pin_data_bit = 0;
  localparam int unsigned pin_clock_bit = 1;
  localparam int unsigned pin_boost_lsb = 2;
  localparam int unsigned pin_sens_hi_bit = 4;
  localparam int unsigned pin_sens_lo_bit = 5;
  localparam int unsigned pin_charger_bit = 6;

  // Configuration captured at the rising chip enable.
  typedef struct packed {
    cfg_mode_e mode;
    logic [1:0] boost;
    sens_level_e sens;
  } cfg_s;

  // Link events reported by the analog front end.
  typedef struct packed {
    logic attach;
    logic hs_handshake_ok;
    logic fixture_detect;
    logic test_packet;
    logic disconnect;
  } link_evt_s;

  // Decode of the three-level pin read as high and low comparators.
  function automatic sens_level_e sens_decode(input logic above_hi, input logic above_lo);
    if (above_hi) begin
      return sens_high;
    end else if (above_lo) begin
      return sens_medium;
    end else begin
      return sens_low;
    end
  endfunction

endpackage

/* redriver_strap_config_status.sv */
// Functional notes
// RULE1: Both bus pins high selects serial mode.
// RULE2: Low chip enable holds reset and shutdown.
// RULE3: Driver holds enable low until supply settles.
// RULE4: Boost latched at enable release only.
// RULE5: Strap mode reads sensitivity as three levels.
// RULE6: Strap mode drives sensitivity pin as flag.
// RULE7: Flag set by fixture-then-test-packet or handshake.
// RULE8: Serial mode leaves the shared pin unused.
// RULE9: Low charger input enables the charger controller.
// RULE10: Attach and handshake conditions reported outside.
// RULE11: Levels come from straps or serial bus.
// RULE12: Flag clears in reset and on disconnect.
module redriver_strap_config_status (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Chip enable pin, active low reset of the device.
  input wire logic chip_enable_n,
  // Straps sampled at the release of the chip enable.
  input wire logic serial_data_in,
  input wire logic serial_clock_in,
  input wire logic [1:0] boost_strap,
  input wire logic sens_above_hi,
  input wire logic sens_above_lo,
  // Levels written over the serial bus in serial mode.
  input wire logic [1:0] bus_boost,
  input wire logic [1:0] bus_sens,
  // Link events from the front end.
  input wire redriver_pkg::link_evt_s link_evt,
  // Charger enable pin, active low.
  input wire logic charger_port_enable_n,
  // Shared sensitivity and speed flag pin.
  output logic sensitivity_or_speed_flag_o,
  output logic sensitivity_or_speed_flag_oe,
  // Attach flag on the shared serial clock pin.
  output logic attach_detect_flag_o,
  output logic attach_detect_flag_oe,
  // Status and configuration outputs.
  output logic active_q,
  output redriver_pkg::cfg_s cfg_q,
  output logic [1:0] boost_level_q,
  output logic [1:0] sens_level_q,
  output logic charger_enable_q,
  output logic high_speed_flag_q
);

  // Two-flop synchronisers for every pin input; stage one feeds stage two only.
  logic [redriver_pkg::pin_w-1:0] pin_s1_q;
  logic [redriver_pkg::pin_w-1:0] pin_s2_q;
  logic cen_n_prev_q; // Previous synchronised chip enable, for the release edge.
  logic fixture_seen_q; // Fixture detected from an unconnected state.
  logic rise;

  // Synchronise the asynchronous pins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {charger_port_enable_n, sens_above_lo, sens_above_hi, boost_strap,
                   serial_clock_in, serial_data_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Chip enable passes its own two flops too.
  logic cen_s1_q;
  logic cen_s2_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cen_s1_q <= 1'b0;
      cen_s2_q <= 1'b0;
      cen_n_prev_q <= 1'b0;
    end else begin
      cen_s1_q <= chip_enable_n;
      cen_s2_q <= cen_s1_q;
      cen_n_prev_q <= cen_s2_q;
    end
  end

  // Release edge of the chip enable; straps are caught only here.
  assign rise = cen_s2_q && !cen_n_prev_q;

  // Active state follows the synchronised enable.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= cen_s2_q; // see RULE2
    end
  end

  // Strap capture: mode, boost and sensitivity frozen until the next release edge of the chip enable.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= '{mode: redriver_pkg::mode_strap, boost: redriver_pkg::boost_reset,
                 sens: redriver_pkg::sens_medium};
    end else if (rise) begin
      // Both bus pins pulled up means serial configuration.
      cfg_q.mode <= (pin_s2_q[redriver_pkg::pin_data_bit] &&
                     pin_s2_q[redriver_pkg::pin_clock_bit]) ?
                    redriver_pkg::mode_serial : redriver_pkg::mode_strap; // see RULE1
      cfg_q.boost <= pin_s2_q[redriver_pkg::pin_boost_lsb +: redriver_pkg::boost_w]; // see RULE4
      cfg_q.sens <= redriver_pkg::sens_decode(pin_s2_q[redriver_pkg::pin_sens_hi_bit],
                                              pin_s2_q[redriver_pkg::pin_sens_lo_bit]); // see RULE5
    end
  end

  // Effective levels pick straps or bus values by mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boost_level_q <= redriver_pkg::boost_reset;
      sens_level_q <= redriver_pkg::sens_medium;
    end else if (!active_q) begin
      boost_level_q <= redriver_pkg::boost_reset;
      sens_level_q <= redriver_pkg::sens_medium;
    end else if (cfg_q.mode == redriver_pkg::mode_serial) begin
      boost_level_q <= bus_boost; // see RULE11
      sens_level_q <= bus_sens; // see RULE11
    end else begin
      boost_level_q <= cfg_q.boost; // see RULE11
      sens_level_q <= cfg_q.sens; // see RULE11
    end
  end

  // Charger controller enable, inverted from the active-low pin.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      charger_enable_q <= 1'b0;
    end else begin
      charger_enable_q <= active_q && !pin_s2_q[redriver_pkg::pin_charger_bit]; // see RULE9
    end
  end

  // Fixture tracking: kept through a test packet, cleared on disconnect.
  // A fixture and a disconnect in one cycle keep the fixture, as the set wins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fixture_seen_q <= 1'b0;
    end else if (!active_q) begin
      fixture_seen_q <= 1'b0;
    end else if (link_evt.fixture_detect) begin
      fixture_seen_q <= 1'b1; // see RULE7
    end else if (link_evt.disconnect) begin
      fixture_seen_q <= 1'b0; // see RULE12
    end
  end

  // High-speed flag: set by handshake or fixture then test packet.
  // Set wins over a disconnect in the same cycle so no event is lost.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      high_speed_flag_q <= 1'b0;
    end else if (!active_q) begin
      high_speed_flag_q <= 1'b0; // see RULE12
    end else if (link_evt.hs_handshake_ok || (fixture_seen_q && link_evt.test_packet)) begin
      high_speed_flag_q <= 1'b1; // see RULE7
    end else if (link_evt.disconnect) begin
      high_speed_flag_q <= 1'b0; // see RULE12
    end
  end

  // Shared pin drivers; in serial mode both status pins stay undriven.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sensitivity_or_speed_flag_o <= 1'b0;
      sensitivity_or_speed_flag_oe <= 1'b0;
      attach_detect_flag_o <= 1'b0;
      attach_detect_flag_oe <= 1'b0;
    end else begin
      // Pin mode after reset turns the sensitivity input into the flag output.
      sensitivity_or_speed_flag_oe <= active_q && !rise &&
                                      cfg_q.mode == redriver_pkg::mode_strap; // see RULE6, RULE8
      sensitivity_or_speed_flag_o <= high_speed_flag_q; // see RULE6
      // Attach reported on the serial clock pin, only in pin mode.
      attach_detect_flag_oe <= active_q && !rise &&
                               cfg_q.mode == redriver_pkg::mode_strap; // see RULE10
      attach_detect_flag_o <= active_q && link_evt.attach; // see RULE10
    end
  end

  // The speed flag reaches the pin one cycle after it is set.
  a_flag_to_pin: assert property (@(posedge ref_clk) disable iff (rst) // see RULE6
    $rose(high_speed_flag_q) |=> sensitivity_or_speed_flag_o)
    else $error("speed flag not driven on pin");

  // Serial mode never drives the shared pin.
  a_serial_pin_idle: assert property (@(posedge ref_clk) disable iff (rst) // see RULE8
    cfg_q.mode == redriver_pkg::mode_serial |-> !sensitivity_or_speed_flag_oe)
    else $error("shared pin driven in serial mode");

  // Handshake sets the flag in the next cycle while active.
  a_handshake_sets: assert property (@(posedge ref_clk) disable iff (rst) // see RULE7
    active_q && link_evt.hs_handshake_ok |=> high_speed_flag_q)
    else $error("handshake did not set flag");

  // Flag is low after inactivity.
  a_flag_reset: assert property (@(posedge ref_clk) disable iff (rst) // see RULE12
    !active_q |=> !high_speed_flag_q)
    else $error("flag set while in reset");

  // Boost stays fixed except at the release edge.
  a_boost_hold: assert property (@(posedge ref_clk) disable iff (rst) // see RULE4
    !rise |=> $stable(cfg_q.boost))
    else $error("boost changed outside release");

  // Both bus pins high at the release edge select serial mode.
  a_mode_select: assert property (@(posedge ref_clk) disable iff (rst) // see RULE1
    rise && pin_s2_q[redriver_pkg::pin_data_bit] && pin_s2_q[redriver_pkg::pin_clock_bit] |=>
      cfg_q.mode == redriver_pkg::mode_serial)
    else $error("serial mode not chosen");

  // A high charger pin while active keeps the charger disabled.
  a_charger_pin: assert property (@(posedge ref_clk) disable iff (rst) // see RULE9
    active_q && pin_s2_q[redriver_pkg::pin_charger_bit] |=> !charger_enable_q)
    else $error("charger enabled with pin high");

  // Inactive device drives no status pin two cycles on.
  a_shutdown_quiet: assert property (@(posedge ref_clk) disable iff (rst) // see RULE2
    !cen_s2_q [*2] |=> !attach_detect_flag_oe && !sensitivity_or_speed_flag_oe)
    else $error("pin driven in shutdown");

  // With no handshake and no fixture seen, a clear flag stays clear.
  a_packet_needs_fixture: assert property (@(posedge ref_clk) disable iff (rst) // see RULE7
    active_q && !high_speed_flag_q && !fixture_seen_q && !link_evt.hs_handshake_ok |=>
      !high_speed_flag_q)
    else $error("flag set without fixture or handshake");

  // A disconnect with no set event clears the flag in the next cycle.
  a_disconnect_clears: assert property (@(posedge ref_clk) disable iff (rst) // see RULE12
    link_evt.disconnect && !link_evt.hs_handshake_ok &&
      !(fixture_seen_q && link_evt.test_packet) |=> !high_speed_flag_q)
    else $error("flag kept after disconnect");

endmodule

/* board_straps.sv */
// Board side: reset driver and strap resistors seen by the redriver.
module board_straps (
  // Clock of the board model.
  input wire logic ref_clk,
  // Supply monitor and strap choices from the bench.
  input wire logic power_good,
  input wire logic serial_sel,
  input wire logic [1:0] boost_sel,
  input wire logic [1:0] sens_sel,
  // Pins towards the device.
  output logic chip_enable_n,
  output logic serial_data_in,
  output logic serial_clock_in,
  output logic [1:0] boost_strap,
  output logic sens_above_hi,
  output logic sens_above_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  // Enable stays low while the supply is not good; release waits one cycle after it settles.
  always_ff @(posedge ref_clk) begin
    chip_enable_n <= power_good;
  end
  // Pull-ups select serial mode; floating pins fall to the weak pull-down.
  assign serial_data_in = serial_sel;
  assign serial_clock_in = serial_sel;
  assign boost_strap = boost_sel;
  // Three-level pin as two comparators: 2 high, 1 floating, 0 low.
  assign sens_above_hi = (sens_sel == 2'h2);
  assign sens_above_lo = (sens_sel != 2'h0);
endmodule

/* redriver_strap_config_status_tb.sv */
// Bench for the strap loader; inputs change on the falling edge.
module redriver_strap_config_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, power_good, serial_sel, charger_port_enable_n;
  logic [1:0] boost_sel, sens_sel, bus_boost, bus_sens, boost_level_q, sens_level_q;
  redriver_pkg::link_evt_s link_evt;
  redriver_pkg::cfg_s cfg_q;
  logic chip_enable_n, sda, scl, hi, lo, so, soe, ao, aoe, active_q, chg_q, hs_q;
  logic [1:0] boost_strap;
  int err_total, total_checks;
  board_straps board_straps_i (.ref_clk(ref_clk), .power_good(power_good),
    .serial_sel(serial_sel), .boost_sel(boost_sel), .sens_sel(sens_sel),
    .chip_enable_n(chip_enable_n), .serial_data_in(sda), .serial_clock_in(scl),
    .boost_strap(boost_strap), .sens_above_hi(hi), .sens_above_lo(lo));
  redriver_strap_config_status redriver_strap_config_status_i (.ref_clk(ref_clk),
    .rst(rst), .chip_enable_n(chip_enable_n), .serial_data_in(sda),
    .serial_clock_in(scl), .boost_strap(boost_strap), .sens_above_hi(hi),
    .sens_above_lo(lo), .bus_boost(bus_boost), .bus_sens(bus_sens),
    .link_evt(link_evt), .charger_port_enable_n(charger_port_enable_n),
    .sensitivity_or_speed_flag_o(so), .sensitivity_or_speed_flag_oe(soe),
    .attach_detect_flag_o(ao), .attach_detect_flag_oe(aoe), .active_q(active_q),
    .cfg_q(cfg_q), .boost_level_q(boost_level_q), .sens_level_q(sens_level_q),
    .charger_enable_q(chg_q), .high_speed_flag_q(hs_q));
  // One comparison; values are widened so every field fits.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Power cycle the device with the given straps, then let the loader settle.
  task automatic boot(input logic ser, input logic [1:0] b, input logic [1:0] s);
    power_good = 1'b0;
    serial_sel = ser;
    boost_sel = b;
    sens_sel = s;
    cyc(4);
    chk({7'h0, active_q}, 8'h00);
    power_good = 1'b1;
    cyc(8);
  endtask
  // Strap mode: straps latched, later strap moves ignored, pin turns output.
  task automatic t_strap();
    boot(1'b0, 2'h3, 2'h2);
    chk({3'h0, cfg_q}, 8'h0e);
    chk({4'h0, boost_level_q, sens_level_q}, 8'h0e);
    chk({5'h0, active_q, soe, aoe}, 8'h07);
    boost_sel = 2'h1;
    sens_sel = 2'h0;
    cyc(5);
    chk({3'h0, cfg_q}, 8'h0e);
    $display("strap test done");
  endtask
  // Handshake, fixture then packet, disconnect and attach flags.
  task automatic t_flags();
    link_evt.hs_handshake_ok = 1'b1;
    cyc(1);
    link_evt.hs_handshake_ok = 1'b0;
    cyc(2);
    chk({6'h0, hs_q, so}, 8'h03);
    link_evt.disconnect = 1'b1;
    cyc(1);
    link_evt.disconnect = 1'b0;
    cyc(2);
    chk({6'h0, hs_q, so}, 8'h00);
    // A test packet with no fixture before it must not set the flag.
    link_evt.test_packet = 1'b1;
    cyc(1);
    link_evt.test_packet = 1'b0;
    cyc(2);
    chk({6'h0, hs_q, so}, 8'h00);
    link_evt.fixture_detect = 1'b1;
    cyc(1);
    link_evt.fixture_detect = 1'b0;
    link_evt.test_packet = 1'b1;
    cyc(1);
    link_evt.test_packet = 1'b0;
    link_evt.attach = 1'b1;
    cyc(3);
    chk({6'h0, hs_q, ao}, 8'h03);
    charger_port_enable_n = 1'b0;
    cyc(5);
    chk({7'h0, chg_q}, 8'h01);
    charger_port_enable_n = 1'b1;
    cyc(5);
    chk({7'h0, chg_q}, 8'h00);
    $display("flag test done");
  endtask
  // Serial mode: bus levels used, shared pins released.
  task automatic t_serial();
    link_evt = '0;
    boot(1'b1, 2'h2, 2'h0);
    chk({7'h0, cfg_q.mode}, 8'h01);
    chk({7'h0, hs_q}, 8'h00);
    chk({4'h0, boost_level_q, sens_level_q}, 8'h04);
    chk({6'h0, soe, aoe}, 8'h00);
    power_good = 1'b0;
    cyc(6);
    chk({6'h0, active_q, hs_q}, 8'h00);
    $display("serial test done");
  endtask
  // Strap mode again with medium, then low sensitivity and boost straps.
  task automatic t_strap_levels();
    boot(1'b0, 2'h1, 2'h1);
    chk({3'h0, cfg_q}, 8'h05);
    chk({5'h0, active_q, soe, aoe}, 8'h07);
    boot(1'b0, 2'h0, 2'h0);
    chk({3'h0, cfg_q}, 8'h00);
    chk({4'h0, boost_level_q, sens_level_q}, 8'h00);
    $display("strap level test done");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Watchdog sized well beyond the hundred or so cycles the tests take.
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    power_good = 1'b0;
    serial_sel = 1'b0;
    boost_sel = 2'h0;
    sens_sel = 2'h1;
    bus_boost = 2'h1;
    bus_sens = 2'h0;
    link_evt = '0;
    charger_port_enable_n = 1'b1;
    err_total = 0;
    total_checks = 0;
    cyc(16);
    rst = 1'b0;
    t_strap();
    t_flags();
    t_serial();
    t_strap_levels();
    finish_test();
  end
endmodule
